// ===== src/rwl_regs.svh
// What this block does
// - Scheme field 00 disables protection; any other value, reset 11, keeps it on.
// - Scheme field ignores direct writes; changes only with arming pattern 11000.
// - Status bit 2 high when protected bits locked, low when writable.
// - Password field bits 7..3 is write-only; unknown patterns do nothing.
// - Pattern 10011 unlocks protected bits and clears the status bit.
// - Pattern 10101 relocks protected bits and sets the status bit.
// - Open and close act only with scheme field 11; disabled means writable.
// - Unlock lasts 32 core clock cycles; open again restarts the count.
// - Divider, watchdog enable, power-down, shutdown ignore writes while locked.
`ifndef RWL_REGS_SVH
`define RWL_REGS_SVH

`define RWL_ADDR_PASSWORD 8'h00
`define RWL_ADDR_PROTECTED 8'h01

`define RWL_PASS_MSB 7
`define RWL_PASS_LSB 3
`define RWL_STATUS_BIT 2
`define RWL_MODE_MSB 1
`define RWL_MODE_LSB 0

`define RWL_PASS_ARM 5'h18
`define RWL_PASS_OPEN 5'h13
`define RWL_PASS_CLOSE 5'h15

`define RWL_MODE_OFF 2'h0
`define RWL_MODE_ON 2'h3
`define RWL_MODE_RESET 2'h3

`define RWL_DIV_MSB 2
`define RWL_DIV_LSB 0
`define RWL_WDT_BIT 3
`define RWL_PD_BIT 4
`define RWL_SD_BIT 5
`define RWL_PROT_RESET 6'h00

`define RWL_OPEN_CYCLES 6'h20

`endif

// ===== src/rwl_pkg.sv
package rwl_pkg;
    typedef enum logic [1:0] {
        RWL_LOCKED = 2'b01,
        RWL_OPEN = 2'b10
    } rwl_lock_t;
endpackage

// ===== src/rwl_relock_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "rwl_regs.svh"
module rwl_relock_timer (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic start_i,
    input wire logic stop_i,
    output logic expire_o
);
    logic [5:0] count;
    logic [5:0] next_count;

    always_comb begin
        next_count = count;
        if (start_i) begin
            next_count = `RWL_OPEN_CYCLES;
        end else if (stop_i) begin
            next_count = 6'h00;
        end else if (count != 6'h00) begin
            next_count = count - 6'h01;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count <= 6'h00;
        end else begin
            count <= next_count;
        end
    end

    // Last cycle of the window, unless a restart or close overrides it
    assign expire_o = (count == 6'h01) && !start_i && !stop_i;
endmodule
`default_nettype wire

// ===== src/rwl_write_lock.sv
`timescale 1ns/1ps
`default_nettype none
`include "rwl_regs.svh"
module rwl_write_lock (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic [2:0] clock_divider_field_o,
    output logic watchdog_enable_bit_o,
    output logic power_down_bit_o,
    output logic shutdown_bit_o,
    output logic protect_status_o,
    output logic scheme_enabled_o
);
    logic [1:0] mode;
    logic [1:0] next_mode;
    rwl_pkg::rwl_lock_t lock_state;
    rwl_pkg::rwl_lock_t next_lock_state;
    logic next_status;
    logic next_enabled;
    logic [5:0] prot;
    logic [5:0] next_prot;
    logic [7:0] next_rdata;
    logic [4:0] pass_in;
    logic pw_wr;
    logic prot_wr;
    logic patterns_live;
    logic open_hit;
    logic close_hit;
    logic expire;

    assign pass_in = reg_wdata_i[`RWL_PASS_MSB:`RWL_PASS_LSB];
    assign pw_wr = reg_wr_i && (reg_addr_i == `RWL_ADDR_PASSWORD);
    assign prot_wr = reg_wr_i && (reg_addr_i == `RWL_ADDR_PROTECTED);
    assign patterns_live = (mode == `RWL_MODE_ON);
    // Anything else written to the password field falls through untouched
    assign open_hit = pw_wr && patterns_live && (pass_in == `RWL_PASS_OPEN);
    assign close_hit = pw_wr && patterns_live && (pass_in == `RWL_PASS_CLOSE);

    rwl_relock_timer u_timer (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .start_i(open_hit),
        .stop_i(close_hit),
        .expire_o(expire)
    );

    // Scheme field and lock state
    always_comb begin
        next_mode = mode;
        next_lock_state = lock_state;
        if (pw_wr && (pass_in == `RWL_PASS_ARM)) begin
            // Mode bits only land together with the arming pattern
            next_mode = reg_wdata_i[`RWL_MODE_MSB:`RWL_MODE_LSB];
            // Re-entering the scheme starts locked, never half open
            next_lock_state = rwl_pkg::RWL_LOCKED;
        end else begin
            case (lock_state)
                rwl_pkg::RWL_LOCKED: begin
                    if (open_hit) begin
                        next_lock_state = rwl_pkg::RWL_OPEN;
                    end
                end
                rwl_pkg::RWL_OPEN: begin
                    if (close_hit || expire) begin
                        next_lock_state = rwl_pkg::RWL_LOCKED;
                    end
                end
                default: begin
                    next_lock_state = rwl_pkg::RWL_LOCKED;
                end
            endcase
        end
        next_enabled = (next_mode != `RWL_MODE_OFF);
        next_status = next_enabled && (next_lock_state == rwl_pkg::RWL_LOCKED);
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode <= `RWL_MODE_RESET;
            lock_state <= rwl_pkg::RWL_LOCKED;
            protect_status_o <= 1'b1;
            scheme_enabled_o <= 1'b1;
        end else begin
            mode <= next_mode;
            lock_state <= next_lock_state;
            protect_status_o <= next_status;
            scheme_enabled_o <= next_enabled;
        end
    end

    // Protected bits and read path
    always_comb begin
        next_prot = prot;
        // Status flop already folds in a disabled scheme
        if (prot_wr && !protect_status_o) begin
            next_prot = reg_wdata_i[5:0];
        end
        next_rdata = 8'h00;
        if (reg_rd_i) begin
            if (reg_addr_i == `RWL_ADDR_PASSWORD) begin
                next_rdata = {5'h00, protect_status_o, mode};
            end else if (reg_addr_i == `RWL_ADDR_PROTECTED) begin
                next_rdata = {2'h0, prot};
            end else begin
                next_rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prot <= `RWL_PROT_RESET;
            reg_rdata_o <= 8'h00;
        end else begin
            prot <= next_prot;
            reg_rdata_o <= next_rdata;
        end
    end

    assign clock_divider_field_o = prot[`RWL_DIV_MSB:`RWL_DIV_LSB];
    assign watchdog_enable_bit_o = prot[`RWL_WDT_BIT];
    assign power_down_bit_o = prot[`RWL_PD_BIT];
    assign shutdown_bit_o = prot[`RWL_SD_BIT];

    // Checks
    // Age counter stands in for a 32-long repetition, which the tools would unroll
    logic [6:0] open_age;
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            open_age <= 7'h00;
        end else if (open_hit || lock_state == rwl_pkg::RWL_LOCKED) begin
            open_age <= 7'h00;
        end else begin
            open_age <= open_age + 7'h01;
        end
    end

    sequence s_open_write;
        pw_wr && (mode == `RWL_MODE_ON) && (pass_in == `RWL_PASS_OPEN);
    endsequence

    sequence s_quiet_pw;
        !pw_wr;
    endsequence

    a_mode_on_decode: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        scheme_enabled_o == (mode != `RWL_MODE_OFF))
        else $error("scheme enable does not follow mode field");

    a_mode_direct_ignored: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (pw_wr && pass_in != `RWL_PASS_ARM) |=> $stable(mode))
        else $error("mode changed without arming pattern");

    a_mode_arm_load: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (pw_wr && pass_in == `RWL_PASS_ARM) |=> (mode == $past(reg_wdata_i[1:0])))
        else $error("mode not loaded by arming pattern");

    a_read_value: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (reg_rd_i && reg_addr_i == `RWL_ADDR_PASSWORD)
        |=> (reg_rdata_o == {5'h00, $past(protect_status_o), $past(mode)}))
        else $error("password register read value wrong");

    a_open_unlocks: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        s_open_write |=> !protect_status_o)
        else $error("open pattern did not unlock");

    a_close_locks: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (pw_wr && mode == `RWL_MODE_ON && pass_in == `RWL_PASS_CLOSE) |=> protect_status_o)
        else $error("close pattern did not lock");

    a_disabled_writable: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (mode == `RWL_MODE_OFF) |-> !protect_status_o)
        else $error("status set while scheme disabled");

    // A reopen pushes the relock out, so the exact end is checked on the age counter
    a_open_window: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        s_open_write ##1 s_quiet_pw [*8] |-> !protect_status_o)
        else $error("unlock window closed too early");

    a_no_early_relock: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (lock_state == rwl_pkg::RWL_OPEN && open_age < 7'h1F && !pw_wr) |=> !protect_status_o)
        else $error("relocked before 32 cycles");

    a_relock_due: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (lock_state == rwl_pkg::RWL_OPEN && open_age == 7'h1F && !pw_wr) |=> protect_status_o)
        else $error("no relock after 32 cycles");

    a_open_age_bound: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        open_age <= 7'h20)
        else $error("unlock lasted over 32 cycles");

    a_unknown_pass_idle: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (pw_wr && pass_in != `RWL_PASS_ARM && pass_in != `RWL_PASS_OPEN
            && pass_in != `RWL_PASS_CLOSE && lock_state == rwl_pkg::RWL_LOCKED)
        |=> ($stable(protect_status_o) && $stable(mode)))
        else $error("unknown pattern changed protection");

    a_arm_relocks: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (pw_wr && pass_in == `RWL_PASS_ARM && reg_wdata_i[1:0] == `RWL_MODE_ON) |=> protect_status_o)
        else $error("scheme re-entered unlocked");

    a_status_mirror: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        protect_status_o == ((mode != `RWL_MODE_OFF) && (lock_state == rwl_pkg::RWL_LOCKED)))
        else $error("status bit does not follow lock state");

    a_locked_hold: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (prot_wr && protect_status_o) |=> $stable(prot))
        else $error("protected bits changed while locked");

    a_unlocked_write: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (prot_wr && !protect_status_o) |=> (prot == $past(reg_wdata_i[5:0])))
        else $error("protected write lost while unlocked");

    a_scheme_off_free: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (prot_wr && mode == `RWL_MODE_OFF) |=> (prot == $past(reg_wdata_i[5:0])))
        else $error("protected write lost with scheme off");

    a_prot_read: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (reg_rd_i && reg_addr_i == `RWL_ADDR_PROTECTED)
        |=> (reg_rdata_o == {2'h0, $past(prot)}))
        else $error("protected register read value wrong");
endmodule
`default_nettype wire

// ===== dv/rwl_write_lock_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "rwl_regs.svh"
module rwl_write_lock_test;
    logic core_clk_i;
    logic rst_b_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o;
    logic [2:0] div;
    logic wdt, pd, sd, status, scheme;
    logic [7:0] prot;
    logic [7:0] flags;
    int error_cnt = 0;
    int n_checks = 0;
    assign prot = {2'h0, sd, pd, wdt, div};
    assign flags = {6'h00, scheme, status};
    rwl_write_lock u_dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .clock_divider_field_o(div), .watchdog_enable_bit_o(wdt),
        .power_down_bit_o(pd), .shutdown_bit_o(sd), .protect_status_o(status),
        .scheme_enabled_o(scheme));
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    task automatic give_verdict();
        if (error_cnt == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Strobe sampled at the second edge; outputs checked 1 ns later
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(reg_rdata_o, exp);
    endtask
    task automatic t_reset();
        rd(`RWL_ADDR_PASSWORD, 8'h07);
        rd(`RWL_ADDR_PROTECTED, 8'h00);
        chk(flags, 8'h03);
    endtask
    task automatic t_refused();
        wr(`RWL_ADDR_PROTECTED, 8'h3F);
        chk(prot, 8'h00);
        wr(`RWL_ADDR_PASSWORD, 8'hF8);
        chk(flags, 8'h03);
        wr(`RWL_ADDR_PASSWORD, 8'h00);
        rd(`RWL_ADDR_PASSWORD, 8'h07);
        rd(8'h02, 8'h00);
    endtask
    task automatic t_open_close();
        wr(`RWL_ADDR_PASSWORD, 8'h9B);
        chk(flags, 8'h02);
        wr(`RWL_ADDR_PROTECTED, 8'h2A);
        chk(prot, 8'h2A);
        rd(`RWL_ADDR_PASSWORD, 8'h03);
        wr(`RWL_ADDR_PASSWORD, 8'hA8);
        chk(flags, 8'h03);
        wr(`RWL_ADDR_PROTECTED, 8'h15);
        chk(prot, 8'h2A);
        rd(`RWL_ADDR_PASSWORD, 8'h07);
    endtask
    // Reopen part way through; the window must restart from the second write
    task automatic t_timer();
        wr(`RWL_ADDR_PASSWORD, 8'h9B);
        repeat (20) @(posedge core_clk_i);
        wr(`RWL_ADDR_PASSWORD, 8'h9B);
        chk(flags, 8'h02);
        repeat (31) @(posedge core_clk_i);
        #1;
        chk(flags, 8'h02);
        @(posedge core_clk_i);
        #1;
        chk(flags, 8'h03);
    endtask
    task automatic t_mode();
        wr(`RWL_ADDR_PASSWORD, 8'hC0);
        chk(flags, 8'h00);
        rd(`RWL_ADDR_PASSWORD, 8'h00);
        wr(`RWL_ADDR_PASSWORD, 8'hA8);
        chk(flags, 8'h00);
        wr(`RWL_ADDR_PROTECTED, 8'h07);
        chk(prot, 8'h07);
        wr(`RWL_ADDR_PASSWORD, 8'hC1);
        chk(flags, 8'h03);
        wr(`RWL_ADDR_PASSWORD, 8'h9B);
        chk(flags, 8'h03);
        wr(`RWL_ADDR_PASSWORD, 8'hC3);
        rd(`RWL_ADDR_PASSWORD, 8'h07);
    endtask
    // Whole run is about 120 cycles; generous margin
    initial begin
        #200000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        repeat (20) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_refused();
        t_open_close();
        t_timer();
        t_mode();
        give_verdict();
    end
endmodule
`default_nettype wire
